// >>> shared/dst_pkg.sv
// shared constants, command codes and bit helpers of the disc sequencer
`default_nettype none
package dst_pkg;
   // timing at a 100 ns reference clock
   localparam int unsigned CLK_NS    = 100;
   localparam int unsigned START_NS  = 16000;
   localparam int unsigned SECTOR_NS = 527000;
   localparam int unsigned PRE_NS    = 28000;
   localparam int unsigned TMR_W     = 13;
   localparam logic [TMR_W-1:0] START_CYC =
      TMR_W'((START_NS + CLK_NS - 1) / CLK_NS);
   localparam int unsigned PRE_CYC_D = (SECTOR_NS - PRE_NS) / CLK_NS;
   localparam logic [TMR_W-1:0] TMR_MAX = 13'h1fff;
   // geometry
   localparam logic [5:0] LAST_SECT = 6'h3f;
   localparam logic [5:0] LAST_BAND = 6'h3f;
   localparam logic [5:0] LAST_WORD = 6'h3f;
   localparam logic [2:0] LAST_STEP = 3'h5;
   localparam logic [5:0] IMM_SKIP  = 6'h02;
   localparam int unsigned WORD_W   = 24;
   localparam int unsigned CNT_W    = 15;
   // address word fields (bit 23 is the word's most significant bit)
   localparam int unsigned UNIT_LSB    = 13;
   localparam int unsigned BAND_LSB    = 6;
   localparam int unsigned SECT_LSB    = 0;
   localparam int unsigned INHIBIT_BIT = 9;
   localparam int unsigned ARM_WR_BIT  = 0;

   typedef enum logic [2:0] {
      OP_NONE, OP_ALERT, OP_LOAD, OP_CONN_RD, OP_CONN_WR, OP_ARM, OP_SENSE
   } dst_op_t;

   // word bit carried by track t at bit step s: track t holds octal
   // digits t and t+4, each sent most significant bit first
   function automatic logic [4:0] dst_bit_idx(input logic [1:0] t,
                                              input logic [2:0] s);
      int d;
      int b;
      d = int'(t) + ((s >= 3'h3) ? 4 : 0);
      b = (s >= 3'h3) ? int'(s) - 3 : int'(s);
      return 5'(23 - (3 * d + b));
   endfunction
endpackage
`default_nettype wire

// >>> shared/dst_link_if.sv
// link between the disc sequencer and the host word channel
`default_nettype none
interface dst_link_if;
   logic                 cmd_valid;
   dst_pkg::dst_op_t     cmd_op;
   logic [23:0]          cmd_word;
   logic                 chan_conn;
   logic [23:0]          wdata;
   logic                 wvalid;
   logic [23:0]          rdata;
   logic                 rvalid;
   logic                 wreq;
   logic                 eor;
   logic                 sect_irq;
   logic [5:0]           pin_sector;
   logic                 pin_valid;
   logic                 busy;
   logic                 err;

   modport dev (
      input  cmd_valid, cmd_op, cmd_word, chan_conn, wdata, wvalid,
      output rdata, rvalid, wreq, eor, sect_irq, pin_sector, pin_valid,
             busy, err
   );
   modport hst (
      output cmd_valid, cmd_op, cmd_word, chan_conn, wdata, wvalid,
      input  rdata, rvalid, wreq, eor, sect_irq, pin_sector, pin_valid,
             busy, err
   );
endinterface
`default_nettype wire

// >>> hw/dst_dev.sv
// disc end: sector sequencing, four-track bit transfer, band stepping
`default_nettype none
// Behaviour
// - transfers always start at a sector's first word
// - unsupplied tail words of a sector written zero
// - host disconnects at zero count, takes nothing more
// - sector wrap advances band by one by default
// - inhibit bit keeps band fixed at wrap
// - sense returns sector now arriving under heads
// - immediate start sector is reported sector plus two
// - end-of-record after last sector; host reloads in gap
// - armed search interrupts 28 us before target sector
// - host answers sector interrupt with a connect
// - four tracks carry four bits in parallel
// - band field of address selects heads
// - data starts 16 us after sector mark
// - continuing past unit's final sector flags error unless inhibit bit set
// - index pulse starts each of 64 sectors
module dst_dev #(
   parameter int unsigned PRE_CYC = dst_pkg::PRE_CYC_D
) (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst,
   // host channel link
   dst_link_if.dev         lnk,
   // disc timing and data
   input  wire logic       sector_mark,
   input  wire logic       bit_tick,
   input  wire logic [3:0] rd_nib,
   output logic      [3:0] wr_nib,
   output logic            wr_gate,
   output logic      [5:0] band_sel,
   output logic      [1:0] unit_sel
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_WAIT, ST_LEAD, ST_DATA, ST_GAP
   } dst_state_t;

   dst_state_t                    state;
   logic [5:0]                    sector_cnt;
   logic [dst_pkg::TMR_W-1:0]     sect_tmr;
   logic [1:0]                    unit;
   logic [5:0]                    band;
   logic [5:0]                    sect;
   logic                          inhibit;
   logic                          writing;
   logic                          wrap_end;
   logic [2:0]                    step;
   logic [5:0]                    wcnt;
   logic [23:0]                   wbuf;
   logic [23:0]                   rbuf;
   logic [23:0]                   next_rbuf;
   logic [3:0]                    next_nib;
   logic [5:0]                    next_sect;
   logic [dst_pkg::TMR_W-1:0]     pre_cyc;

   assign next_sect = sector_cnt + 6'h01;
   assign pre_cyc   = dst_pkg::TMR_W'(PRE_CYC);

   // each track contributes or takes one bit per tick
   always_comb begin
      next_rbuf = rbuf;
      next_nib  = 4'h0;
      for (int t = 0; t < 4; t++) begin
         next_rbuf[dst_pkg::dst_bit_idx(2'(t), step)] = rd_nib[t];
         next_nib[t] = wbuf[dst_pkg::dst_bit_idx(2'(t), step)];
      end
   end

   // sector counter and timer; head selection follows at each mark
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sector_cnt <= 6'h00;
         sect_tmr   <= '0;
         band_sel   <= 6'h00;
         unit_sel   <= 2'h0;
      end else if (sector_mark) begin
         sector_cnt <= next_sect;
         sect_tmr   <= '0;
         band_sel   <= band;
         unit_sel   <= unit;
      end else if (sect_tmr != dst_pkg::TMR_MAX) begin
         sect_tmr <= sect_tmr + 13'h0001;
      end
   end

   // write word buffer: host word, or zero once the host has left
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wbuf <= 24'h000000;
      end else if (lnk.wreq && !lnk.chan_conn) begin
         wbuf <= 24'h000000;
      end else if (lnk.wvalid) begin
         wbuf <= lnk.wdata;
      end
   end

   // commands and the transfer sequence
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state          <= ST_IDLE;
         unit           <= 2'h0;
         band           <= 6'h00;
         sect           <= 6'h00;
         inhibit        <= 1'b0;
         writing        <= 1'b0;
         wrap_end       <= 1'b0;
         step           <= 3'h0;
         wcnt           <= 6'h00;
         rbuf           <= 24'h000000;
         wr_nib         <= 4'h0;
         wr_gate        <= 1'b0;
         lnk.rdata      <= 24'h000000;
         lnk.rvalid     <= 1'b0;
         lnk.wreq       <= 1'b0;
         lnk.eor        <= 1'b0;
         lnk.sect_irq   <= 1'b0;
         lnk.pin_sector <= 6'h00;
         lnk.pin_valid  <= 1'b0;
         lnk.busy       <= 1'b0;
         lnk.err        <= 1'b0;
      end else begin
         lnk.rvalid    <= 1'b0;
         lnk.wreq      <= 1'b0;
         lnk.eor       <= 1'b0;
         lnk.sect_irq  <= 1'b0;
         lnk.pin_valid <= 1'b0;
         lnk.busy      <= (state != ST_IDLE);
         if (lnk.cmd_valid) begin
            unique case (lnk.cmd_op)
               dst_pkg::OP_ALERT: begin
                  if (state == ST_IDLE) begin
                     inhibit <= lnk.cmd_word[dst_pkg::INHIBIT_BIT];
                     lnk.err <= 1'b0;
                  end else begin
                     lnk.err <= 1'b1;
                  end
               end
               dst_pkg::OP_LOAD: begin
                  // reloading the address mid-transfer is refused
                  if (state == ST_IDLE) begin
                     unit <= lnk.cmd_word[dst_pkg::UNIT_LSB +: 2];
                     band <= lnk.cmd_word[dst_pkg::BAND_LSB +: 6];
                     sect <= lnk.cmd_word[dst_pkg::SECT_LSB +: 6];
                  end else begin
                     lnk.err <= 1'b1;
                  end
               end
               dst_pkg::OP_SENSE: begin
                  lnk.pin_sector <= sector_cnt;
                  lnk.pin_valid  <= 1'b1;
               end
               dst_pkg::OP_CONN_RD,
               dst_pkg::OP_CONN_WR: begin
                  if (state == ST_IDLE || state == ST_WAIT) begin
                     writing  <= (lnk.cmd_op == dst_pkg::OP_CONN_WR);
                     wrap_end <= 1'b0;
                     state    <= ST_WAIT;
                  end
               end
               dst_pkg::OP_ARM: begin
                  if (state == ST_IDLE) begin
                     writing  <= lnk.cmd_word[dst_pkg::ARM_WR_BIT];
                     wrap_end <= 1'b0;
                     state    <= ST_WAIT;
                  end
               end
               default: ;
            endcase
         end
         unique case (state)
            ST_IDLE: ;
            ST_WAIT: begin
               // search runs without the channel; warn ahead of target
               if (!lnk.chan_conn && next_sect == sect
                   && sect_tmr == pre_cyc) begin
                  lnk.sect_irq <= 1'b1;
               end
               if (sector_mark && lnk.chan_conn && next_sect == sect) begin
                  state    <= ST_LEAD;
                  wr_gate  <= writing;
                  lnk.wreq <= writing;
               end
            end
            ST_LEAD: begin
               if (sect_tmr == dst_pkg::START_CYC) begin
                  state <= ST_DATA;
                  step  <= 3'h0;
                  wcnt  <= 6'h00;
               end
            end
            ST_DATA: begin
               if (bit_tick) begin
                  if (writing) begin
                     wr_nib <= next_nib;
                  end else begin
                     rbuf <= next_rbuf;
                  end
                  if (step == dst_pkg::LAST_STEP) begin
                     step <= 3'h0;
                     if (!writing) begin
                        lnk.rdata  <= next_rbuf;
                        lnk.rvalid <= 1'b1;
                     end
                     if (wcnt == dst_pkg::LAST_WORD) begin
                        state   <= ST_GAP;
                        wr_gate <= 1'b0;
                        sect    <= sect + 6'h01;
                        if (sect == dst_pkg::LAST_SECT) begin
                           lnk.eor <= 1'b1;
                           if (!inhibit) begin
                              if (band == dst_pkg::LAST_BAND) begin
                                 wrap_end <= 1'b1;
                              end else begin
                                 band <= band + 6'h01;
                              end
                           end
                        end
                     end else begin
                        wcnt     <= wcnt + 6'h01;
                        lnk.wreq <= writing;
                     end
                  end else begin
                     step <= step + 3'h1;
                  end
               end
            end
            ST_GAP: begin
               wr_nib <= 4'h0;
               if (sector_mark) begin
                  if (!lnk.chan_conn) begin
                     state <= ST_IDLE;
                  end else if (wrap_end) begin
                     lnk.err <= 1'b1;
                     state   <= ST_IDLE;
                  end else begin
                     state    <= ST_LEAD;
                     wr_gate  <= writing;
                     lnk.wreq <= writing;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> hw/dst_host.sv
// host end: word channel with counter, sector interrupt and immediate start
`default_nettype none
module dst_host (
   // clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 rst,
   // link to the disc end
   dst_link_if.hst                   lnk,
   // program side commands
   input  wire logic                 u_valid,
   input  wire dst_pkg::dst_op_t     u_op,
   input  wire logic [23:0]          u_word,
   input  wire logic [14:0]          u_count,
   input  wire logic                 u_imm,
   input  wire logic [7:0]           u_imm_addr,
   // program side data and status
   input  wire logic [23:0]          u_wdata,
   output logic      [23:0]          u_rdata,
   output logic                      u_rvalid,
   output logic                      u_wtake,
   output logic                      u_eor,
   output logic                      u_idle
);
   typedef enum logic [2:0] {
      H_IDLE, H_SENSE, H_ALERT, H_LOAD, H_CONN
   } dst_hstate_t;

   dst_hstate_t          hstate;
   logic [14:0]          count;
   logic                 arm_pend;
   logic                 armed_wr;
   logic                 imm_pass1;
   logic [5:0]           start;
   logic                 xfer;

   assign xfer = lnk.chan_conn && (lnk.rvalid || lnk.wreq);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hstate        <= H_IDLE;
         count         <= 15'h0000;
         arm_pend      <= 1'b0;
         armed_wr      <= 1'b0;
         imm_pass1     <= 1'b0;
         start         <= 6'h00;
         lnk.cmd_valid <= 1'b0;
         lnk.cmd_op    <= dst_pkg::OP_NONE;
         lnk.cmd_word  <= 24'h000000;
         lnk.chan_conn <= 1'b0;
         lnk.wdata     <= 24'h000000;
         lnk.wvalid    <= 1'b0;
         u_rdata       <= 24'h000000;
         u_rvalid      <= 1'b0;
         u_wtake       <= 1'b0;
         u_eor         <= 1'b0;
         u_idle        <= 1'b1;
      end else begin
         lnk.cmd_valid <= 1'b0;
         lnk.wvalid    <= 1'b0;
         u_rvalid      <= 1'b0;
         u_wtake       <= 1'b0;
         u_eor         <= lnk.eor;
         u_idle        <= (hstate == H_IDLE) && !lnk.busy && !arm_pend;
         // word exchange; the last counted word drops the connection
         if (xfer) begin
            if (lnk.rvalid) begin
               u_rdata  <= lnk.rdata;
               u_rvalid <= 1'b1;
            end else begin
               lnk.wdata  <= u_wdata;
               lnk.wvalid <= 1'b1;
               u_wtake    <= 1'b1;
            end
            count <= count - 15'h0001;
            if (count == 15'h0001) begin
               lnk.chan_conn <= 1'b0;
            end
         end
         // second pass of a whole band, set up inside the gap
         if (lnk.eor && imm_pass1) begin
            imm_pass1     <= 1'b0;
            count         <= {3'h0, start, 6'h00};
            lnk.chan_conn <= (start != 6'h00);
         end
         unique case (hstate)
            H_IDLE: begin
               if (lnk.sect_irq && arm_pend) begin
                  arm_pend      <= 1'b0;
                  lnk.cmd_valid <= 1'b1;
                  lnk.cmd_op    <= armed_wr ? dst_pkg::OP_CONN_WR
                                            : dst_pkg::OP_CONN_RD;
                  count         <= u_count;
                  lnk.chan_conn <= (u_count != 15'h0000);
               end else if (u_imm) begin
                  lnk.cmd_valid <= 1'b1;
                  lnk.cmd_op    <= dst_pkg::OP_SENSE;
                  hstate        <= H_SENSE;
               end else if (u_valid) begin
                  lnk.cmd_valid <= 1'b1;
                  lnk.cmd_op    <= u_op;
                  lnk.cmd_word  <= u_word;
                  if (u_op == dst_pkg::OP_CONN_RD
                      || u_op == dst_pkg::OP_CONN_WR) begin
                     count         <= u_count;
                     lnk.chan_conn <= (u_count != 15'h0000);
                  end
                  if (u_op == dst_pkg::OP_ARM) begin
                     arm_pend <= 1'b1;
                     armed_wr <= u_word[dst_pkg::ARM_WR_BIT];
                  end
               end
            end
            H_SENSE: begin
               if (lnk.pin_valid) begin
                  start  <= lnk.pin_sector + dst_pkg::IMM_SKIP;
                  hstate <= H_ALERT;
               end
            end
            H_ALERT: begin
               lnk.cmd_valid <= 1'b1;
               lnk.cmd_op    <= dst_pkg::OP_ALERT;
               lnk.cmd_word  <= 24'h000001 << dst_pkg::INHIBIT_BIT;
               hstate        <= H_LOAD;
            end
            H_LOAD: begin
               lnk.cmd_valid <= 1'b1;
               lnk.cmd_op    <= dst_pkg::OP_LOAD;
               // unit lands in [14:13], band in [11:6]
               lnk.cmd_word  <= {9'h000, u_imm_addr[7:6], 1'b0,
                                 u_imm_addr[5:0], start};
               hstate        <= H_CONN;
            end
            H_CONN: begin
               lnk.cmd_valid <= 1'b1;
               lnk.cmd_op    <= dst_pkg::OP_CONN_RD;
               // seven bits so a start of zero asks for the whole band
               count         <= {2'h0, 7'h40 - {1'b0, start}, 6'h00};
               lnk.chan_conn <= 1'b1;
               imm_pass1     <= 1'b1;
               hstate        <= H_IDLE;
            end
            default: hstate <= H_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> bench/dst_props.sv
// link assertions for the disc sequencer, both ends joined
`default_nettype none
module dst_props (
   // clock and reset
   input wire logic             ref_clk,
   input wire logic             rst,
   // link signals
   input wire logic             cmd_valid,
   input wire dst_pkg::dst_op_t cmd_op,
   input wire logic             chan_conn,
   input wire logic             wvalid,
   input wire logic             rvalid,
   input wire logic             wreq,
   input wire logic             eor,
   input wire logic             sect_irq,
   input wire logic             pin_valid,
   input wire logic             busy,
   input wire logic             err
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_sense;
      cmd_valid && cmd_op == dst_pkg::OP_SENSE;
   endsequence
   sequence s_connect;
      cmd_valid && (cmd_op == dst_pkg::OP_CONN_RD ||
                    cmd_op == dst_pkg::OP_CONN_WR);
   endsequence
   chk_sense_answer: assert property (
      s_sense |=> pin_valid ##1 !pin_valid) else $error("sense unanswered");
   chk_eor_pulse: assert property (
      eor |-> busy ##1 !eor) else $error("bad end of record");
   chk_irq_search: assert property (
      sect_irq |-> !chan_conn ##1 !sect_irq) else $error("bad sector irq");
   chk_irq_connect: assert property (
      sect_irq |=> s_connect) else $error("irq not followed by connect");
   chk_write_answer: assert property (
      wvalid |-> $past(wreq) && $past(chan_conn))
      else $error("write word without request");
   chk_refuse_err: assert property (
      (cmd_valid && (cmd_op == dst_pkg::OP_ALERT ||
                     cmd_op == dst_pkg::OP_LOAD)) ##1 busy |-> err)
      else $error("command while busy not refused");
   chk_err_sticky: assert property (
      err && !(cmd_valid && cmd_op == dst_pkg::OP_ALERT) |=> err)
      else $error("error flag lost");
   chk_xfer_busy: assert property (
      rvalid || wreq |-> busy) else $error("data while idle");
   chk_rvalid_pulse: assert property (
      rvalid |=> !rvalid) else $error("read word too long");
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the disc sequencer, both ends joined
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
   $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int SLEN = 1400;
   localparam int PRE  = 280;
   logic             ref_clk = 1'b0;
   logic             rst = 1'b1;
   logic             sector_mark = 1'b0;
   logic             bit_tick = 1'b0;
   logic [3:0]       rd_nib = 4'h0;
   logic [3:0]       wr_nib;
   logic             wr_gate;
   logic [5:0]       band_sel;
   logic [1:0]       unit_sel;
   logic             u_rvalid;
   logic             u_wtake;
   logic             u_eor;
   logic             u_idle;
   logic             u_valid = 1'b0;
   dst_pkg::dst_op_t u_op = dst_pkg::OP_NONE;
   logic [23:0]      u_word = 24'h0;
   logic [14:0]      u_count = 15'h0;
   logic             u_imm = 1'b0;
   logic [7:0]       u_imm_addr = 8'h47;
   logic [23:0]      u_wdata = 24'hffffff;
   logic [23:0]      u_rdata;
   logic [5:0]       cur = 6'h0;
   int               phase = 0;
   int               slen = SLEN;
   int               cyc = 0;
   int               num_errors = 0;
   int               n_checks = 0;

   dst_link_if lnk ();
   dst_dev #(.PRE_CYC(SLEN - PRE)) i_dst_dev (.ref_clk(ref_clk), .rst(rst),
      .lnk(lnk), .sector_mark(sector_mark), .bit_tick(bit_tick),
      .rd_nib(rd_nib), .wr_nib(wr_nib), .wr_gate(wr_gate),
      .band_sel(band_sel), .unit_sel(unit_sel));
   dst_host i_dst_host (.ref_clk(ref_clk), .rst(rst), .lnk(lnk),
      .u_valid(u_valid), .u_op(u_op), .u_word(u_word), .u_count(u_count),
      .u_imm(u_imm), .u_imm_addr(u_imm_addr), .u_wdata(u_wdata),
      .u_rdata(u_rdata), .u_rvalid(u_rvalid), .u_wtake(u_wtake),
      .u_eor(u_eor), .u_idle(u_idle));
   dst_props i_dst_props (.ref_clk(ref_clk), .rst(rst),
      .cmd_valid(lnk.cmd_valid), .cmd_op(lnk.cmd_op),
      .chan_conn(lnk.chan_conn), .wvalid(lnk.wvalid), .rvalid(lnk.rvalid),
      .wreq(lnk.wreq), .eor(lnk.eor), .sect_irq(lnk.sect_irq),
      .pin_valid(lnk.pin_valid), .busy(lnk.busy), .err(lnk.err));

   always #50 ref_clk = ~ref_clk;

   function automatic logic [23:0] dw(input logic [5:0] s, input int i);
      return {s, 6'(i), 12'h5a3};
   endfunction
   // track t carries octal digits t and t+4, msb first
   function automatic logic [3:0] nib(input logic [23:0] w, input int k);
      logic [3:0] n;
      for (int t = 0; t < 4; t++)
         n[t] = w[23 - 3 * (t + 4 * ((k % 6) / 3)) - (k % 3)];
      return n;
   endfunction

   // disc: ticks before 160 cycles must be ignored, data from phase 162
   always @(negedge ref_clk) begin
      phase = (phase >= slen - 1) ? 0 : phase + 1;
      sector_mark <= (phase == 0);
      bit_tick <= phase >= 141 && phase <= 1311 && phase % 3 == 0;
      if (phase >= 162 && phase <= 1311 && phase % 3 == 0)
         rd_nib <= nib(dw(cur, (phase - 162) / 18), (phase - 162) / 3);
      else
         rd_nib <= ~rd_nib;
   end
   always @(posedge ref_clk) cur <= rst ? 6'h0 : cur + 6'(sector_mark);
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc > 60000) begin
         num_errors++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic do_reset();
      rst = 1'b1;
      repeat (3) @(negedge ref_clk);
      rst = 1'b0;
   endtask
   task automatic cmd(input dst_pkg::dst_op_t op, input logic [23:0] w);
      u_op = op;
      u_word = w;
      u_valid = 1'b1;
      @(negedge ref_clk);
      u_valid = 1'b0;
      @(negedge ref_clk);
   endtask
   task automatic start(input dst_pkg::dst_op_t op, input logic [5:0] b,
                        input logic [5:0] s, input logic [14:0] n);
      cmd(dst_pkg::OP_ALERT, 24'h0);
      cmd(dst_pkg::OP_LOAD, {12'h0, b, s});
      u_count = n;
      cmd(op, 24'h0);
   endtask
   // idle marks are sped up; only the sectors under test run at full length
   task automatic spin(input logic [5:0] s);
      int i;
      for (i = 0; i < 4000 && lnk.busy !== 1'b0; i++) @(negedge ref_clk);
      slen = 8;
      for (i = 0; i < 2000 && cur != s; i++) @(negedge ref_clk);
      slen = SLEN;
   endtask

   task automatic t_wrap(input logic [5:0] band);
      int i;
      int ne;
      int nu;
      spin(6'd61);
      start(dst_pkg::OP_CONN_RD, band, 6'd63, 15'd128);
      for (i = 0; i < 3000 && lnk.rvalid !== 1'b1; i++) @(negedge ref_clk);
      `CHK(lnk.rdata, dw(6'd63, 0))
      `CHK(cur, 6'd63)
      ne = 0;
      nu = 0;
      for (i = 0; i < 3000 && cur != 6'd0; i++) begin
         ne += (lnk.eor === 1'b1);
         nu += (u_eor === 1'b1);
         @(negedge ref_clk);
      end
      repeat (3) @(negedge ref_clk);
      `CHK(ne, 1)
      `CHK(nu, 1)
      `CHK(lnk.err, band == 6'h3f)
      if (band != 6'h3f)
         `CHK(band_sel, band + 6'd1)
      $display("test wrap done");
   endtask

   task automatic t_write();
      int i;
      int nq;
      int nw;
      int nf;
      int nz;
      int nt;
      spin(6'd10);
      start(dst_pkg::OP_CONN_WR, 6'd2, 6'd12, 15'd20);
      nq = 0;
      nw = 0;
      nf = 0;
      nz = 0;
      nt = 0;
      for (i = 0; i < 5000 && cur != 6'd13; i++) begin
         @(negedge ref_clk);
         if (cur == 6'd12) begin
            nq += (lnk.wreq === 1'b1);
            nw += (lnk.wvalid === 1'b1);
            nt += (u_wtake === 1'b1);
            if (bit_tick && phase >= 180 && phase <= 480)
               nf += (wr_nib !== 4'hf) + (wr_gate !== 1'b1);
            if (bit_tick && phase >= 600 && phase <= 1280)
               nz += (wr_nib !== 4'h0);
            if (phase == 710)
               cmd(dst_pkg::OP_LOAD, 24'h0);
         end
      end
      `CHK(nq, 64)
      `CHK(nw, 20)
      `CHK(nt, 20)
      `CHK(nf, 0)
      `CHK(nz, 0)
      `CHK(lnk.err, 1'b1)
      `CHK(wr_gate, 1'b0)
      $display("test write done");
   endtask

   task automatic t_arm();
      int i;
      spin(6'd20);
      start(dst_pkg::OP_ARM, 6'd5, 6'd22, 15'd64);
      for (i = 0; i < 5000 && lnk.sect_irq !== 1'b1; i++) @(negedge ref_clk);
      `CHK(cur, 6'd21)
      `CHK(phase >= SLEN-PRE-2 && phase <= SLEN-PRE+3, 1'b1)
      for (i = 0; i < 3000 && lnk.rvalid !== 1'b1; i++) @(negedge ref_clk);
      `CHK(cur, 6'd22)
      `CHK(lnk.rdata, dw(6'd22, 0))
      @(negedge ref_clk);
      `CHK(u_rdata, dw(6'd22, 0))
      `CHK(u_rvalid, 1'b1)
      $display("test arm done");
   endtask

   task automatic t_imm();
      int i;
      logic [23:0] al;
      logic [23:0] ld;
      logic [5:0]  ps;
      logic        rc;
      spin(6'd60);
      u_imm = 1'b1;
      @(negedge ref_clk);
      u_imm = 1'b0;
      for (i = 0; i < 6000 && lnk.eor !== 1'b1; i++) begin
         if (lnk.pin_valid === 1'b1)
            ps = lnk.pin_sector;
         if (lnk.cmd_valid === 1'b1 && lnk.cmd_op == dst_pkg::OP_ALERT)
            al = lnk.cmd_word;
         if (lnk.cmd_valid === 1'b1 && lnk.cmd_op == dst_pkg::OP_LOAD)
            ld = lnk.cmd_word;
         @(negedge ref_clk);
      end
      `CHK(lnk.eor, 1'b1)
      `CHK(ps, 6'd60)
      `CHK(al[9], 1'b1)
      `CHK(ld[5:0], 6'd62)
      `CHK(ld[11:6], 6'd7)
      `CHK(ld[14:13], 2'h1)
      // the reload keeps the channel connected through the gap
      rc = 1'b1;
      for (i = 0; i < 500 && cur == 6'd63; i++) begin
         rc &= lnk.chan_conn === 1'b1;
         @(negedge ref_clk);
      end
      repeat (3) @(negedge ref_clk);
      `CHK(rc, 1'b1)
      `CHK(band_sel, 6'd7)
      `CHK(unit_sel, 2'h1)
      for (i = 0; i < 300 && lnk.rvalid !== 1'b1; i++) @(negedge ref_clk);
      `CHK(lnk.rdata, dw(6'd0, 0))
      $display("test immediate done");
   endtask

   initial begin
      do_reset();
      t_wrap(6'd3);
      t_write();
      t_arm();
      t_wrap(6'h3f);
      cmd(dst_pkg::OP_ALERT, 24'h0);
      `CHK(lnk.err, 1'b0)
      `CHK(u_idle, 1'b1)
      do_reset();
      t_imm();
      do_reset();
      print_verdict();
   end
endmodule
`default_nettype wire
